/* rtl/page_table_walk_decoder.sv */
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "walk_defines.svh"

module page_table_walk_decoder
    import walk_pkg::*;
(
    input  wire logic        pclk,        // clock, 20 MHz
    input  wire logic        presetn,     // async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB write
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic        xlat_valid,  // core translation request
    input  xlat_req_s        xlat_in,     // core request fields
    output logic             xlat_busy,   // walk in progress
    output logic             xlat_done,   // one-cycle completion pulse
    output xlat_resp_s       xlat_out,    // translation result
    output logic             mem_req,     // table fetch request
    output logic [31:0]      mem_addr,    // table fetch address
    input  wire logic [31:0] mem_rdata,   // fetched descriptor
    input  wire logic        mem_ack      // fetch data valid
);

    walk_state_e state_r;
    logic [31:0] va_r;
    logic        write_r;
    logic        priv_r;
    logic [31:0] l1_desc_r;
    logic [31:0] l2_desc_r;
    logic        mem_req_r;
    logic [31:0] mem_addr_r;
    logic        done_pulse_r;
    logic        busy_r;
    xlat_resp_s  res_r;

    logic [4:0]  ctrl_r;
    logic [17:0] tbase_r;                 // table_base_pointer 31:14
    logic [31:0] domain_r;
    logic [31:0] swva_r;
    logic        sw_pend_r;
    logic        done_st_r;

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    logic        apb_wr;
    logic        start_core;
    logic        start_sw;
    logic [31:0] start_va;

    page_size_e  pg_size;
    logic [31:0] pg_pa;
    logic [7:0]  pg_ap_all;
    logic [1:0]  pg_ap_sel;
    logic [1:0]  pg_cb;
    logic        pg_bad;

    xlat_resp_s  fin;
    logic [31:0] rd_data;
    logic        rd_err;

    // level one entry: 16KB-aligned table, one word per 1MB
    function automatic logic [31:0] l1_addr(input logic [17:0] base,
                                            input logic [31:0] va);
        l1_addr = {base, va[31:20], 2'h0};
    endfunction : l1_addr

    // level two entry inside a coarse or fine table
    function automatic logic [31:0] l2_addr(input logic [31:0] d1,
                                            input logic [31:0] va);
        if (d1[1:0] == `L1_FINE)
            l2_addr = {d1[31:12], va[19:10], 2'h0};
        else
            l2_addr = {d1[31:10], va[19:12], 2'h0};
    endfunction : l2_addr

    // permission field against mode, direction and the S and R controls
    function automatic logic ap_ok(input logic [1:0] ap,
                                   input logic       s,
                                   input logic       r,
                                   input logic       priv,
                                   input logic       wr);
        case (ap)
            2'h0: begin
                if (s && !r)
                    ap_ok = priv && !wr;
                else if (!s && r)
                    ap_ok = !wr;
                else
                    ap_ok = 1'b0;
            end
            2'h1:    ap_ok = priv;
            2'h2:    ap_ok = priv || !wr;
            default: ap_ok = 1'b1;
        endcase
    endfunction : ap_ok

    assign apb_wr     = psel && penable && pready_r && pwrite;
    assign start_core = (state_r == WS_IDLE) && xlat_valid;
    assign start_sw   = (state_r == WS_IDLE) && !xlat_valid && sw_pend_r;
    assign start_va   = xlat_valid ? xlat_in.va : swva_r;

    page_desc_decode u_l2_decode (
        .desc      (l2_desc_r),
        .va        (va_r),
        .from_fine (l1_desc_r[1:0] == `L1_FINE),
        .size      (pg_size),
        .pa        (pg_pa),
        .ap_all    (pg_ap_all),
        .ap_sel    (pg_ap_sel),
        .cb        (pg_cb),
        .bad       (pg_bad)
    );

    // walk sequencing and table fetches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= WS_IDLE;
            va_r       <= 32'h00000000;
            write_r    <= 1'b0;
            priv_r     <= 1'b0;
            l1_desc_r  <= 32'h00000000;
            l2_desc_r  <= 32'h00000000;
            mem_req_r  <= 1'b0;
            mem_addr_r <= 32'h00000000;
        end else begin
            case (state_r)
                WS_IDLE: begin
                    if (start_core || start_sw) begin
                        va_r       <= start_va;
                        write_r    <= xlat_valid ? xlat_in.write
                                                 : ctrl_r[`CTRL_WR];
                        priv_r     <= xlat_valid ? xlat_in.priv
                                                 : ctrl_r[`CTRL_PRIV];
                        mem_req_r  <= 1'b1;
                        mem_addr_r <= l1_addr(tbase_r, start_va);
                        state_r    <= WS_L1;
                    end
                end
                WS_L1: begin
                    if (mem_ack) begin
                        l1_desc_r <= mem_rdata;
                        if (mem_rdata[1:0] == `L1_COARSE ||
                            mem_rdata[1:0] == `L1_FINE) begin
                            mem_addr_r <= l2_addr(mem_rdata, va_r);
                            state_r    <= WS_L2;
                        end else begin
                            mem_req_r <= 1'b0;
                            state_r   <= WS_CHECK;
                        end
                    end
                end
                WS_L2: begin
                    if (mem_ack) begin
                        l2_desc_r <= mem_rdata;
                        mem_req_r <= 1'b0;
                        state_r   <= WS_CHECK;
                    end
                end
                WS_CHECK: begin
                    state_r <= WS_IDLE;
                end
                default: begin
                    mem_req_r <= 1'b0;
                    state_r   <= WS_IDLE;
                end
            endcase
        end
    end

    // outcome of a walk: translation, domain and permission checks
    always_comb begin
        logic [3:0] dom;
        logic [1:0] dacv;
        logic [1:0] ap;
        logic       sect;
        dom  = l1_desc_r[8:5];
        dacv = domain_r[{dom, 1'b0} +: 2];
        sect = (l1_desc_r[1:0] == `L1_SECTION);
        ap   = sect ? l1_desc_r[11:10] : pg_ap_sel;
        fin.pa     = 32'h00000000;
        fin.fault  = 1'b0;
        fin.fsr    = `FS_NONE;
        fin.domain = dom;
        fin.ap     = sect ? {6'h00, l1_desc_r[11:10]} : pg_ap_all;
        fin.cb     = sect ? l1_desc_r[3:2] : pg_cb;
        fin.size   = sect ? SZ_SECTION : pg_size;
        if (l1_desc_r[1:0] == `L1_INVALID) begin
            fin.fault  = 1'b1;
            fin.fsr    = `FS_XLAT_SECT;
            fin.domain = 4'h0;
            fin.ap     = 8'h00;
            fin.cb     = 2'h0;
            fin.size   = SZ_NONE;
        end else if (!sect && pg_bad) begin
            fin.fault = 1'b1;
            fin.fsr   = `FS_XLAT_PAGE;
        end else if (dacv != `DOM_CLIENT && dacv != `DOM_MANAGER) begin
            fin.fault = 1'b1;
            fin.fsr   = sect ? `FS_DOM_SECT : `FS_DOM_PAGE;
        end else if (dacv == `DOM_CLIENT &&
                     !ap_ok(ap, ctrl_r[`CTRL_S], ctrl_r[`CTRL_R],
                            priv_r, write_r)) begin
            fin.fault = 1'b1;
            fin.fsr   = sect ? `FS_PERM_SECT : `FS_PERM_PAGE;
        end else begin
            // address only leaves once every check has passed
            fin.pa = sect ? {l1_desc_r[31:20], va_r[19:0]}
                          : pg_pa;
        end
    end

    // result holding and completion signalling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_r        <= '0;
            done_pulse_r <= 1'b0;
            busy_r       <= 1'b0;
        end else begin
            done_pulse_r <= (state_r == WS_CHECK);
            busy_r       <= !(state_r == WS_CHECK) &&
                            (start_core || start_sw ||
                             state_r != WS_IDLE);
            if (state_r == WS_CHECK)
                res_r <= fin;
        end
    end

    // software-writable control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= `CTRL_RST;
            tbase_r  <= `TBASE_RST;
            domain_r <= `DOMAIN_RST;
            swva_r   <= 32'h00000000;
        end else if (apb_wr) begin
            case (paddr)
                `REG_CTRL:   ctrl_r   <= {pwdata[4:1], 1'b0};
                `REG_TBASE:  tbase_r  <= pwdata[31:`TBASE_LO];
                `REG_DOMAIN: domain_r <= pwdata;
                `REG_SWVA:   swva_r   <= pwdata;
                default: ;
            endcase
        end
    end

    // software start request and sticky completion flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_pend_r <= 1'b0;
            done_st_r <= 1'b0;
        end else begin
            if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_START])
                sw_pend_r <= 1'b1;
            else if (start_sw)
                sw_pend_r <= 1'b0;
            // a completion in the clearing cycle keeps the flag set
            if (state_r == WS_CHECK)
                done_st_r <= 1'b1;
            else if (apb_wr && paddr == `REG_STATUS &&
                     pwdata[`ST_DONE])
                done_st_r <= 1'b0;
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        case (paddr)
            `REG_CTRL:   rd_data = {27'h0000000, ctrl_r[4:1], sw_pend_r};
            `REG_TBASE:  rd_data = {tbase_r, 14'h0000};
            `REG_DOMAIN: rd_data = domain_r;
            `REG_SWVA:   rd_data = swva_r;
            `REG_STATUS: begin
                rd_data[`ST_BUSY]               = busy_r;
                rd_data[`ST_DONE]               = done_st_r;
                rd_data[`ST_FAULT]              = res_r.fault;
                rd_data[`ST_FSR_LO +: 4]        = res_r.fsr;
                rd_data[`ST_DOM_LO +: 4]        = res_r.domain;
                rd_data[`ST_SIZE_LO +: 3]       = res_r.size;
            end
            `REG_PA:     rd_data = res_r.pa;
            `REG_ATTR: begin
                rd_data[7:0]                    = res_r.ap;
                rd_data[`ATTR_CB_LO +: 2]       = res_r.cb;
                rd_data[`ATTR_DOM_LO +: 4]      = res_r.domain;
            end
            default:     rd_err  = 1'b1;
        endcase
    end

    // APB answer: one access cycle, data and error captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && rd_err;
            if (psel && !penable && !pwrite)
                prdata_r <= rd_data;
            else
                prdata_r <= 32'h00000000;
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign xlat_busy = busy_r;
    assign xlat_done = done_pulse_r;
    assign xlat_out  = res_r;
    assign mem_req   = mem_req_r;
    assign mem_addr  = mem_addr_r;

endmodule : page_table_walk_decoder

/* rtl/walk_defines.svh */
`ifndef WALK_DEFINES_SVH
`define WALK_DEFINES_SVH

// register byte offsets on the APB side
`define REG_CTRL      8'h00
`define REG_TBASE     8'h04
`define REG_DOMAIN    8'h08
`define REG_SWVA      8'h0C
`define REG_STATUS    8'h10
`define REG_PA        8'h14
`define REG_ATTR      8'h18

// control register fields
`define CTRL_START    0
`define CTRL_S        1
`define CTRL_R        2
`define CTRL_WR       3
`define CTRL_PRIV     4
`define CTRL_RST      5'h00

// status register fields
`define ST_BUSY       0
`define ST_DONE       1
`define ST_FAULT      2
`define ST_FSR_LO     4
`define ST_DOM_LO     8
`define ST_SIZE_LO    12

// attribute register fields
`define ATTR_CB_LO    8
`define ATTR_DOM_LO   10

// table base keeps bits 31:14, the rest read as zero
`define TBASE_LO      14
`define TBASE_RST     18'h00000
`define DOMAIN_RST    32'h00000000

// descriptor type codes in bits 1:0
`define L1_INVALID    2'h0
`define L1_COARSE     2'h1
`define L1_SECTION    2'h2
`define L1_FINE       2'h3
`define L2_INVALID    2'h0
`define L2_LARGE      2'h1
`define L2_SMALL      2'h2
`define L2_TINY       2'h3

// domain access values
`define DOM_CLIENT    2'h1
`define DOM_MANAGER   2'h3

// fault status codes
`define FS_NONE       4'h0
`define FS_XLAT_SECT  4'h5
`define FS_XLAT_PAGE  4'h7
`define FS_DOM_SECT   4'h9
`define FS_DOM_PAGE   4'hB
`define FS_PERM_SECT  4'hD
`define FS_PERM_PAGE  4'hF

`endif

/* rtl/walk_pkg.sv */
package walk_pkg;

    typedef enum logic [3:0] {
        WS_IDLE  = 4'h1,
        WS_L1    = 4'h2,
        WS_L2    = 4'h4,
        WS_CHECK = 4'h8
    } walk_state_e;

    typedef enum logic [2:0] {
        SZ_NONE    = 3'h0,
        SZ_SECTION = 3'h1,
        SZ_LARGE   = 3'h2,
        SZ_SMALL   = 3'h3,
        SZ_TINY    = 3'h4
    } page_size_e;

    typedef struct packed {
        logic [31:0] va;     // remapped_virtual_address
        logic        write;
        logic        priv;
    } xlat_req_s;

    typedef struct packed {
        logic [31:0] pa;
        logic        fault;
        logic [3:0]  fsr;
        logic [3:0]  domain;
        logic [7:0]  ap;     // access_permission_field(s)
        logic [1:0]  cb;
        page_size_e  size;
    } xlat_resp_s;

endpackage : walk_pkg

/* rtl/page_desc_decode.sv */
`timescale 1ns/1ps
`include "walk_defines.svh"

module page_desc_decode
    import walk_pkg::*;
(
    input  wire logic [31:0] desc,      // level two descriptor
    input  wire logic [31:0] va,        // remapped_virtual_address
    input  wire logic        from_fine, // table was a fine table
    output page_size_e       size,      // decoded page size
    output logic [31:0]      pa,        // physical address
    output logic [7:0]       ap_all,    // permission fields as held
    output logic [1:0]       ap_sel,    // field governing this access
    output logic [1:0]       cb,        // cacheable, bufferable
    output logic             bad        // page translation fault
);

    always_comb begin
        size   = SZ_NONE;
        pa     = 32'h00000000;
        ap_all = 8'h00;
        ap_sel = 2'h0;
        bad    = 1'b0;
        cb     = desc[3:2];
        case (desc[1:0])
            `L2_LARGE: begin
                size   = SZ_LARGE;
                pa     = {desc[31:16], va[15:0]};
                ap_all = desc[11:4];
                case (va[15:14])
                    2'h0:    ap_sel = desc[5:4];
                    2'h1:    ap_sel = desc[7:6];
                    2'h2:    ap_sel = desc[9:8];
                    default: ap_sel = desc[11:10];
                endcase
            end
            `L2_SMALL: begin
                size   = SZ_SMALL;
                pa     = {desc[31:12], va[11:0]};
                ap_all = desc[11:4];
                case (va[11:10])
                    2'h0:    ap_sel = desc[5:4];
                    2'h1:    ap_sel = desc[7:6];
                    2'h2:    ap_sel = desc[9:8];
                    default: ap_sel = desc[11:10];
                endcase
            end
            `L2_TINY: begin
                // coarse tables cannot locate tiny pages
                size   = SZ_TINY;
                bad    = ~from_fine;
                pa     = {desc[31:10], va[9:0]};
                ap_all = {6'h00, desc[5:4]};
                ap_sel = desc[5:4];
            end
            default: begin
                bad = 1'b1;
            end
        endcase
    end

endmodule : page_desc_decode

/* tb/page_table_walk_decoder_props.sv */
`timescale 1ns/1ps
module page_table_walk_decoder_props
    import walk_pkg::*;
(
    input  wire logic        pclk,       // clock
    input  wire logic        presetn,    // reset, active low
    input  wire logic        xlat_valid, // core request
    input  xlat_req_s        xlat_in,    // request fields
    input  wire logic        xlat_busy,  // walk in progress
    input  wire logic        xlat_done,  // completion pulse
    input  xlat_resp_s       xlat_out,   // result
    input  wire logic        mem_req,    // fetch request
    input  wire logic [31:0] mem_addr,   // fetch address
    input  wire logic [31:0] mem_rdata,  // fetched descriptor
    input  wire logic        mem_ack     // fetch strobe
);
    logic [31:0] va_r;
    logic [31:0] d1_r;
    logic [31:0] d2_r;
    logic [31:0] pa_exp;
    logic [1:0]  n_ack_r;
    logic        core_r;
    logic        take;

    assign take = mem_req && mem_ack && core_r;

    // remembers the request and both descriptors of the current walk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            va_r    <= '0;
            d1_r    <= '0;
            d2_r    <= '0;
            n_ack_r <= '0;
            core_r  <= 1'b0;
        end else begin
            // walks started by software carry a hidden address
            if (!xlat_busy) core_r <= xlat_valid;
            if (xlat_valid && !xlat_busy) begin
                va_r    <= xlat_in.va;
                n_ack_r <= 2'h0;
            end else if (take && n_ack_r != 2'h3) begin
                n_ack_r <= n_ack_r + 2'h1;
            end
            if (take && n_ack_r == 2'h0) d1_r <= mem_rdata;
            if (take && n_ack_r == 2'h1) d2_r <= mem_rdata;
        end
    end

    always_comb begin
        case (d2_r[1:0])
            2'h1:    pa_exp = {d2_r[31:16], va_r[15:0]};
            2'h2:    pa_exp = {d2_r[31:12], va_r[11:0]};
            default: pa_exp = {d2_r[31:10], va_r[9:0]};
        endcase
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_l1_take;
        take && n_ack_r == 2'h0;
    endsequence
    sequence s_l2_take;
        take && n_ack_r == 2'h1;
    endsequence
    sequence s_page_done;
        xlat_done && !xlat_out.fault && n_ack_r == 2'h2 && core_r;
    endsequence

    a_l1_addr: assert property (
        $rose(mem_req) && core_r |-> mem_addr[13:0] ==
        {va_r[31:20], 2'b00})
        else $error("level one fetch index wrong");
    a_walk_start: assert property (
        xlat_valid && !xlat_busy |=> xlat_busy && mem_req)
        else $error("walk did not start");
    a_coarse_l2: assert property (
        s_l1_take ##0 mem_rdata[1:0] == 2'h1 |=> mem_req &&
        mem_addr == {d1_r[31:10], va_r[19:12], 2'b00})
        else $error("coarse level two fetch wrong");
    a_fine_l2: assert property (
        s_l1_take ##0 mem_rdata[1:0] == 2'h3 |=> mem_req &&
        mem_addr == {d1_r[31:12], va_r[19:10], 2'b00})
        else $error("fine level two fetch wrong");
    a_l1_end: assert property (
        s_l1_take ##0 !mem_rdata[0] |=> !mem_req ##1 xlat_done)
        else $error("single level walk timing wrong");
    a_l1_fault: assert property (
        s_l1_take ##0 mem_rdata[1:0] == 2'h0 |-> ##2 xlat_out.fault &&
        xlat_out.fsr == 4'h5 && xlat_out.pa == 32'h0)
        else $error("level one invalid fault wrong");
    a_l2_fault: assert property (
        s_l2_take ##0 (mem_rdata[1:0] == 2'h0 || d1_r[1:0] == 2'h1 &&
        mem_rdata[1:0] == 2'h3) |-> ##2 xlat_done && xlat_out.fault &&
        xlat_out.fsr == 4'h7)
        else $error("page translation fault wrong");
    a_page_pa: assert property (
        s_page_done |-> xlat_out.pa == pa_exp)
        else $error("page physical address wrong");
    a_page_attr: assert property (
        s_page_done |-> xlat_out.cb == d2_r[3:2] &&
        xlat_out.domain == d1_r[8:5] &&
        xlat_out.size == page_size_e'(3'(d2_r[1:0]) + 3'h1))
        else $error("page attributes wrong");
    a_page_ap: assert property (
        s_page_done |-> xlat_out.ap == (d2_r[1:0] == 2'h3 ?
        {6'h00, d2_r[5:4]} : d2_r[11:4]))
        else $error("page permission field wrong");
endmodule : page_table_walk_decoder_props

/* tb/table_mem_model.sv */
`timescale 1ns/1ps
module table_mem_model (
    input  wire logic        pclk,      // clock
    input  wire logic        presetn,   // reset, active low
    input  wire logic        mem_req,   // fetch request
    input  wire logic [31:0] mem_addr,  // fetch address
    output logic      [31:0] mem_rdata, // descriptor
    output logic             mem_ack    // data strobe
);
    logic [31:0] tbl [logic [31:0]];
    int          lag = 0;
    int          wait_n;

    // data toggles when not answering so a stale word is never trusted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h5A5A_A5A5;
            wait_n = 0;
        end else if (mem_req && !mem_ack && wait_n >= lag) begin
            mem_ack   <= 1'b1;
            mem_rdata <= tbl.exists(mem_addr) ? tbl[mem_addr] : 32'h0;
            wait_n = 0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) wait_n++;
        end
    end
endmodule : table_mem_model

/* tb/tb_page_table_walk_decoder.sv */
`timescale 1ns/1ps
module tb_page_table_walk_decoder;
    import walk_pkg::*;
    localparam logic [31:0] TB = 32'h0001_0000;
    localparam logic [31:0] CB = 32'h0003_0400;
    localparam logic [31:0] FB = 32'h0004_1000;
    localparam logic [31:0] PB = 32'hDEAD_BC00;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_rdata;
    logic        xlat_valid, xlat_busy, xlat_done, mem_req, mem_ack;
    xlat_req_s   xlat_in;
    xlat_resp_s  xlat_out, e;
    int          n_mismatch, cmp_count;

    page_table_walk_decoder DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xlat_valid(xlat_valid), .xlat_in(xlat_in),
        .xlat_busy(xlat_busy), .xlat_done(xlat_done), .xlat_out(xlat_out),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    table_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    always #25 pclk = ~pclk;

    task automatic chk(input logic [63:0] got, exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, m, input logic err);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        chk({pready, pslverr, wr ? 32'h0 : prdata & m},
            {1'b1, err, wr ? 32'h0 : d}, "apb");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run(input logic [31:0] va, input logic [1:0] t1, t2,
                       input logic [3:0] dom, input int lagv);
        logic [31:0] d1, d2, a2;
        int          n, i;
        e = '0;
        e.domain = dom;
        e.cb = 2'b10;
        a2 = t1 == 2'h1 ? {CB[31:10], va[19:12], 2'b00}
                        : {FB[31:12], va[19:10], 2'b00};
        case (t1)
            2'h1: d1 = {CB[31:10], 1'b0, dom, 3'b100, t1};
            2'h3: d1 = {FB[31:12], 3'b000, dom, 3'b100, t1};
            2'h2: d1 = {12'hABC, 11'h000, dom, 3'b110, t1};
            default: d1 = 32'hFFFF_FFFC;
        endcase
        case (t2)
            2'h1: d2 = {PB[31:16], 4'h0, 8'hE4, 2'b10, t2};
            2'h2: d2 = {PB[31:12], 8'hE4, 2'b10, t2};
            2'h3: d2 = {PB[31:10], 4'h0, 2'b01, 2'b10, t2};
            default: d2 = 32'h0;
        endcase
        mem.tbl[{TB[31:14], va[31:20], 2'b00}] = d1;
        n = t2 == 2'h1 ? (t1 == 2'h1 ? 16 : 64)
                       : (t2 == 2'h2 && t1 == 2'h3 ? 4 : 1);
        for (i = 0; i < n; i++)
            mem.tbl[(a2 & ~(32'(n) * 4 - 1)) + 32'(4 * i)] = d2;
        if (t1 == 2'h2) begin
            e.pa = {12'hABC, va[19:0]};
            e.size = SZ_SECTION;
        end else if (t2 == 2'h1) begin
            e.pa = {PB[31:16], va[15:0]};
            e.ap = 8'hE4;
            e.size = SZ_LARGE;
        end else if (t2 == 2'h2) begin
            e.pa = {PB[31:12], va[11:0]};
            e.ap = 8'hE4;
            e.size = SZ_SMALL;
        end else begin
            e.pa = {PB[31:10], va[9:0]};
            e.ap = 8'h01;
            e.size = SZ_TINY;
        end
        if (t1 == 2'h0) e.fsr = 4'h5;
        else if (t1 != 2'h2 && (t2 == 2'h0 || t1 == 2'h1 && t2 == 2'h3))
            e.fsr = 4'h7;
        else if (t1 == 2'h2 && dom == 4'h3) e.fsr = 4'hD;
        e.fault = e.fsr != 4'h0;
        if (e.fault) e.pa = '0;
        mem.lag = lagv;
        @(posedge pclk);
        xlat_valid <= 1'b1;
        xlat_in    <= '{va: va, write: 1'b0, priv: 1'b1};
        @(posedge pclk);
        xlat_valid <= 1'b0;
        for (i = 0; i < 100 && xlat_done !== 1'b1; i++) @(negedge pclk);
        chk(64'(xlat_done), 64'h1, "walk done");
        if (e.fault)
            chk(64'({xlat_out.pa, xlat_out.fault, xlat_out.fsr}),
                64'({e.pa, e.fault, e.fsr}), "fault result");
        else
            chk(64'(xlat_out), 64'(e), "walk result");
    endtask : run

    task results;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    initial begin
        #(5000 * 50);
        n_mismatch++;
        results();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, xlat_valid} = '0;
        {paddr, pwdata, xlat_in} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 32'h0, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'hFFFF_C000, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, 8'h1C, 32'h0, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, 8'h04, TB, 32'h0, 1'b0);
        apb(1'b1, 8'h08, 32'hFFFF_FF7F, 32'h0, 1'b0);
        for (int k = 0; k < 8; k++)
            run(32'h5A3C_F7E9 + 32'h0131_1357 * k, k < 4 ? 2'h1 : 2'h3,
                2'(k), 4'(k + 5), k % 3);
        run(32'h1234_5678, 2'h2, 2'h0, 4'h9, 1);
        run(32'h1234_5678, 2'h2, 2'h0, 4'h3, 0);
        run(32'hFEDC_BA98, 2'h0, 2'h0, 4'h0, 2);
        apb(1'b0, 8'h10, 32'h0000_0056, 32'h0000_00FF, 1'b0);
        apb(1'b1, 8'h0C, 32'h1234_5678, 32'h0, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0013, 32'h0, 1'b0);
        for (int j = 0; j < 100 && xlat_done !== 1'b1; j++) @(negedge pclk);
        chk(64'(xlat_done), 64'h1, "soft walk done");
        apb(1'b0, 8'h14, 32'hABC4_5678, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, 8'h10, 32'h0000_1302, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, 8'h18, 32'h0000_0E00, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 8'h10, 32'h0000_0002, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0000_1300, 32'hFFFF_FFFF, 1'b0);
        results();
    end
endmodule : tb_page_table_walk_decoder

bind page_table_walk_decoder page_table_walk_decoder_props u_props (
    .pclk(pclk), .presetn(presetn), .xlat_valid(xlat_valid),
    .xlat_in(xlat_in), .xlat_busy(xlat_busy), .xlat_done(xlat_done),
    .xlat_out(xlat_out), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
